/* hw/fsp_ctrl.sv */
// Purpose: Redirects core external writes to flash, times writes and erases
// Assumes: Core waits on flash_busy_flag before its next redirected write
// Notes:   APB answers with one wait state; flash array sits behind fl_op/fl_rd
//
// Contract
// - Redirect bit sends external writes to flash
// - Redirect bit cleared only by software
// - Flash reads only via code moves
// - Bank select picks upper window bank
// - Flash write only clears bits
// - Hardware times writes and erases
// - Scratchpad double-mapped at 0x00-0xFF
// - Scratchpad reachable only when selected
// - No instruction fetch from scratchpad
// - Erase at 0x0400 clears both sectors
// - Erase sets page bytes to 0xFF
// - Erase on write with all enables
// - Scratchpad linear range 0x20000-0x200FF
// - Lower 32 kB always bank zero
// - Busy flag held during write/erase
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module fsp_ctrl #(
   parameter int WRITE_CYCLES = fsp_pkg::WRITE_CYC,
   parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYC
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  fsp_pkg::fsp_xwr_s      core_xwr,
   input  fsp_pkg::fsp_xrd_s      core_xrd,
   input  fsp_pkg::fsp_crd_s      core_crd,
   output fsp_pkg::fsp_xram_s     xram,
   output fsp_pkg::fsp_flop_s     fl_op,
   output fsp_pkg::fsp_flrd_s     fl_rd,
   output logic                   flash_busy_flag
);
   import fsp_pkg::*;

   localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WRITE_CYCLES - 1);
   localparam logic [CNT_W-1:0] ER_LOAD = CNT_W'(ERASE_CYCLES - 1);

   typedef struct packed {
      fsp_st_e          st;
      logic [CNT_W-1:0] cnt;
      logic             redir;
      logic             eras;
      logic             prog;
      logic             scr;
      logic [1:0]       bank;
      logic             busy;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      fsp_xram_s        xram;
      fsp_flop_s        flop;
      fsp_flrd_s        flrd;
   } fsp_state_s;

   fsp_state_s r_reg;
   fsp_state_s r_next;

   // Core address to linear flash address
   function automatic logic [17:0] fsp_map(input logic [15:0] a,
                                           input logic        scr,
                                           input logic [1:0]  bank);
      logic [17:0] lin;
      lin = 18'h0;
      if (scr && (a < SCR_LIMIT)) begin
         lin = SCR_BASE | {10'h0, a[7:0]};
      end else if (a[15]) begin
         lin = {1'b0, bank, a[14:0]};
      end else begin
         lin = {3'b000, a[14:0]};
      end
      return lin;
   endfunction

   logic        apb_acc;
   logic        apb_done;
   logic        hit;
   logic [31:0] rd_val;

   always_comb begin
      apb_acc  = psel && penable && !r_reg.pready;
      apb_done = psel && penable && r_reg.pready;
      hit      = (paddr == OFS_PSC) || (paddr == OFS_FSC) || (paddr == OFS_PBR) || (paddr == OFS_STAT);
      rd_val   = 32'h0;
      case (paddr)
         OFS_PSC: begin
            rd_val[PSC_REDIR_BIT] = r_reg.redir;
            rd_val[PSC_ERASE_BIT] = r_reg.eras;
            rd_val[PSC_SCR_BIT]   = r_reg.scr;
         end
         OFS_FSC:  rd_val[FSC_PROG_BIT] = r_reg.prog;
         OFS_PBR:  rd_val[PBR_BANK_LSB+1:PBR_BANK_LSB] = r_reg.bank;
         OFS_STAT: rd_val[STAT_BUSY_BIT] = r_reg.busy;
         default:  rd_val = 32'h0;
      endcase
   end

   always_comb begin
      r_next            = r_reg;
      r_next.pready     = 1'b0;
      r_next.pslverr    = 1'b0;
      r_next.xram.wr    = 1'b0;
      r_next.xram.rd    = 1'b0;
      r_next.flop.wr    = 1'b0;
      r_next.flop.erase = 1'b0;
      r_next.flrd.valid = 1'b0;

      // One wait state keeps every APB output on a flop
      if (apb_acc) begin
         r_next.pready  = 1'b1;
         r_next.pslverr = !hit;
         r_next.prdata  = pwrite ? 32'h0 : rd_val;
      end
      if (apb_done && pwrite) begin
         case (paddr)
            OFS_PSC: begin
               r_next.redir = pwdata[PSC_REDIR_BIT];
               r_next.eras  = pwdata[PSC_ERASE_BIT];
               r_next.scr   = pwdata[PSC_SCR_BIT];
            end
            OFS_FSC: r_next.prog = pwdata[FSC_PROG_BIT];
            OFS_PBR: r_next.bank = pwdata[PBR_BANK_LSB+1:PBR_BANK_LSB];
            default: r_next.prog = r_reg.prog;
         endcase
      end

      // External reads never see flash
      if (core_xrd.valid) begin
         r_next.xram.rd    = 1'b1;
         r_next.xram.raddr = core_xrd.addr;
      end

      // Fetches bypass the scratchpad overlay
      if (core_crd.valid) begin
         r_next.flrd.valid = 1'b1;
         r_next.flrd.addr  = fsp_map(core_crd.addr, r_reg.scr && !core_crd.fetch, r_reg.bank);
      end

      if (core_xwr.valid) begin
         if (!r_reg.redir) begin
            r_next.xram.wr    = 1'b1;
            r_next.xram.waddr = core_xwr.addr;
            r_next.xram.wdata = core_xwr.data;
         end else if (r_reg.prog && (r_reg.st == FSP_IDLE)) begin
            if (r_reg.eras) begin
               r_next.flop.erase = 1'b1;
               r_next.flop.fill  = ERASED_BYTE;
               r_next.flop.clr_mask = 8'h00;
               if (r_reg.scr && (core_xwr.addr == SCR_BOTH_ADDR)) begin
                  r_next.flop.addr = SCR_BASE;
                  r_next.flop.len  = SCR_BOTH_LEN;
               end else if (r_reg.scr && (core_xwr.addr < SCR_LIMIT)) begin
                  r_next.flop.addr = SCR_BASE | {10'h0, core_xwr.addr[7], 7'h00};
                  r_next.flop.len  = SCR_PAGE_LEN;
               end else begin
                  r_next.flop.addr = fsp_map(core_xwr.addr, 1'b0, r_reg.bank) & ~18'h003FF;
                  r_next.flop.len  = MAIN_PAGE_LEN;
               end
               r_next.st   = FSP_ERASE;
               r_next.cnt  = ER_LOAD;
               r_next.busy = 1'b1;
            end else begin
               r_next.flop.wr       = 1'b1;
               r_next.flop.addr     = fsp_map(core_xwr.addr, r_reg.scr, r_reg.bank);
               r_next.flop.clr_mask = ~core_xwr.data;
               r_next.flop.fill     = 8'h00;
               r_next.flop.len      = 11'h001;
               r_next.st            = FSP_WRITE;
               r_next.cnt           = WR_LOAD;
               r_next.busy          = 1'b1;
            end
         end
      end

      // Busy until the hardware timer runs out
      case (r_reg.st)
         FSP_IDLE: r_next.cnt = r_next.cnt;
         FSP_WRITE, FSP_ERASE: begin
            if (r_reg.cnt == '0) begin
               r_next.st   = FSP_IDLE;
               r_next.busy = 1'b0;
            end else begin
               r_next.cnt  = r_reg.cnt - CNT_W'(1);
            end
         end
         default: begin
            r_next.st   = FSP_IDLE;
            r_next.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_reg       <= '0;
         r_reg.st    <= FSP_IDLE;
         r_reg.bank  <= BANK_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata          = r_reg.prdata;
   assign pready          = r_reg.pready;
   assign pslverr         = r_reg.pslverr;
   assign xram            = r_reg.xram;
   assign fl_op           = r_reg.flop;
   assign fl_rd           = r_reg.flrd;
   assign flash_busy_flag = r_reg.busy;

   logic psc_wr;
   assign psc_wr = psel && penable && pready && pwrite && (paddr == OFS_PSC);

   redir_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      r_reg.redir && !psc_wr |=> r_reg.redir)
      else $error("redirect bit dropped without a software write");

   xwr_route_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_xwr.valid && !r_reg.redir |=> xram.wr && !fl_op.wr && !fl_op.erase)
      else $error("unredirected write did not reach xram");

   xrd_xram_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_xrd.valid |=> xram.rd && (xram.raddr == $past(core_xrd.addr)))
      else $error("external read not sent to xram");

   no_prog_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_xwr.valid && r_reg.redir && !r_reg.prog |=> !fl_op.wr && !fl_op.erase && !xram.wr)
      else $error("redirected write acted without program enable");

   erase_start_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_xwr.valid && r_reg.redir && r_reg.prog && r_reg.eras && !r_reg.busy
      |=> fl_op.erase && flash_busy_flag && (fl_op.fill == ERASED_BYTE))
      else $error("erase not started");

   both_sect_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.erase && r_reg.scr && ($past(core_xwr.addr) == SCR_BOTH_ADDR)
      |-> (fl_op.addr == SCR_BASE) && (fl_op.len == SCR_BOTH_LEN))
      else $error("dual scratchpad erase mapped wrongly");

   low_bank_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.wr && !$past(core_xwr.addr[15]) && !$past(r_reg.scr) |-> (fl_op.addr[17:15] == 3'b000))
      else $error("lower window not bank zero");

   wr_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.wr |-> (fl_op.clr_mask == ~$past(core_xwr.data)))
      else $error("write mask would set bits");

   fetch_scr_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_crd.valid && core_crd.fetch |=> (fl_rd.addr[17] == 1'b0))
      else $error("fetch reached the scratchpad");

   busy_run_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(flash_busy_flag) |-> flash_busy_flag[*8])
      else $error("busy flag dropped early");

   wr_timer_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.wr |-> (r_reg.st == FSP_WRITE) && (r_reg.cnt == WR_LOAD))
      else $error("write timer not loaded");

   scr_wr_map_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.wr && $past(r_reg.scr) && ($past(core_xwr.addr) < SCR_LIMIT)
      |-> (fl_op.addr == (SCR_BASE | {10'h0, $past(core_xwr.addr[7:0])})))
      else $error("scratchpad write mapped wrongly");

   bank_map_a: assert property (@(posedge mclk) disable iff (!nrst)
      fl_op.wr && $past(core_xwr.addr[15]) |-> (fl_op.addr[16:15] == $past(r_reg.bank)))
      else $error("upper window write not in selected bank");

   busy_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
      core_xwr.valid && flash_busy_flag |=> !fl_op.wr && !fl_op.erase)
      else $error("new flash operation while busy");

   busy_end_a: assert property (@(posedge mclk) disable iff (!nrst)
      flash_busy_flag && (r_reg.cnt == '0) |=> !flash_busy_flag)
      else $error("busy flag outlived the timer");

endmodule

/* hw/fsp_pkg.sv */
// Purpose: Shared constants and carriers for the flash soft program/erase controller
// Assumes: 100 MHz mclk, APB register access, byte-wide core moves
// Notes:   Linear flash space is 18 bits; scratchpad sits above main flash
package fsp_pkg;

   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          WRITE_TIME_NS    = 50000;
   localparam int          ERASE_TIME_NS    = 12000000;
   localparam int          WRITE_CYC        = WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam int          ERASE_CYC        = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int          CNT_W            = 21;

   localparam logic [7:0]  OFS_PSC          = 8'h00;
   localparam logic [7:0]  OFS_FSC          = 8'h04;
   localparam logic [7:0]  OFS_PBR          = 8'h08;
   localparam logic [7:0]  OFS_STAT         = 8'h0C;

   localparam int          PSC_REDIR_BIT    = 0;
   localparam int          PSC_ERASE_BIT    = 1;
   localparam int          PSC_SCR_BIT      = 2;
   localparam int          FSC_PROG_BIT     = 0;
   localparam int          PBR_BANK_LSB     = 4;
   localparam int          STAT_BUSY_BIT    = 0;
   localparam logic [1:0]  BANK_RST         = 2'h1;

   localparam logic [17:0] SCR_BASE         = 18'h20000;
   localparam logic [15:0] SCR_LIMIT        = 16'h0100;
   localparam logic [15:0] SCR_BOTH_ADDR    = 16'h0400;
   localparam logic [10:0] MAIN_PAGE_LEN    = 11'h400;
   localparam logic [10:0] SCR_PAGE_LEN     = 11'h080;
   localparam logic [10:0] SCR_BOTH_LEN     = 11'h100;
   localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

   typedef enum logic [1:0] {
      FSP_IDLE  = 2'b00,
      FSP_WRITE = 2'b01,
      FSP_ERASE = 2'b10
   } fsp_st_e;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } fsp_xwr_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } fsp_xrd_s;

   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic [15:0] addr;
   } fsp_crd_s;

   typedef struct packed {
      logic        wr;
      logic [15:0] waddr;
      logic [7:0]  wdata;
      logic        rd;
      logic [15:0] raddr;
   } fsp_xram_s;

   typedef struct packed {
      logic        wr;
      logic        erase;
      logic [17:0] addr;
      logic [7:0]  clr_mask;
      logic [7:0]  fill;
      logic [10:0] len;
   } fsp_flop_s;

   typedef struct packed {
      logic        valid;
      logic [17:0] addr;
   } fsp_flrd_s;

endpackage

/* dv/fsp_core_model.sv */
// Purpose: Core side model issuing external and code moves
// Assumes: One move per call, each pulse one cycle wide
// Notes:   Idle address and data are inverted so stale values never match
`timescale 1ns/1ps
module fsp_core_model (
   input  wire logic        mclk,
   output fsp_pkg::fsp_xwr_s core_xwr,
   output fsp_pkg::fsp_xrd_s core_xrd,
   output fsp_pkg::fsp_crd_s core_crd
);
   import fsp_pkg::*;

   initial begin
      core_xwr = '0;
      core_xrd = '0;
      core_crd = '0;
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      core_xwr <= '{valid: 1'b1, addr: a, data: d};
      @(posedge mclk);
      core_xwr <= '{valid: 1'b0, addr: ~a, data: ~d};
   endtask

   task automatic rd(input logic [15:0] a);
      @(posedge mclk);
      core_xrd <= '{valid: 1'b1, addr: a};
      @(posedge mclk);
      core_xrd <= '{valid: 1'b0, addr: ~a};
   endtask

   task automatic cr(input logic [15:0] a, input logic f);
      @(posedge mclk);
      core_crd <= '{valid: 1'b1, fetch: f, addr: a};
      @(posedge mclk);
      core_crd <= '{valid: 1'b0, fetch: ~f, addr: ~a};
   endtask
endmodule

/* dv/test_fsp_ctrl.sv */
// Purpose: Self-checking bench for the flash program/erase controller
// Assumes: Shortened write and erase counts
// Notes:   Stimulus keeps interrupts notionally off and avoids the top reserved region
`timescale 1ns/1ps
module test_fsp_ctrl;
   import fsp_pkg::*;
   localparam int W = 20;
   localparam int E = 40;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, flash_busy_flag, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   fsp_xwr_s    core_xwr;
   fsp_xrd_s    core_xrd;
   fsp_crd_s    core_crd;
   fsp_xram_s   xram;
   fsp_flop_s   fl_op;
   fsp_flrd_s   fl_rd;
   int          fail_count = 0;
   int          samples_checked = 0;

   fsp_ctrl #(.WRITE_CYCLES(W), .ERASE_CYCLES(E)) fsp_ctrl_i (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_xwr(core_xwr), .core_xrd(core_xrd), .core_crd(core_crd), .xram(xram),
      .fl_op(fl_op), .fl_rd(fl_rd), .flash_busy_flag(flash_busy_flag));

   fsp_core_model fsp_core_model_i (
      .mclk(mclk), .core_xwr(core_xwr), .core_xrd(core_xrd), .core_crd(core_crd));

   always #5 mclk = ~mclk;

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", n, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Ready and read data taken at the same rising edge
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         wrap_up;
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("read", r, x);
   endtask

   // Falling edges from the check point until busy drops; exp is exact
   task automatic busy_wait(input int exp);
      int n;
      n = 0;
      while (flash_busy_flag === 1'b1 && n < exp + 10) begin
         @(negedge mclk);
         n++;
      end
      if (n >= exp + 10) begin
         fail_count++;
         wrap_up;
      end
      chk("busy_cycles", 64'(n), 64'(exp));
   endtask

   task automatic t_regs;
      rchk(OFS_PSC, 32'h0);
      rchk(OFS_FSC, 32'h0);
      rchk(OFS_PBR, 32'h10);
      rchk(OFS_STAT, 32'h0);
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      chk("slverr", e, 1'b1);
      rchk(8'h20, 32'h0);
      chk("slverr", e, 1'b1);
   endtask

   task automatic t_xram;
      fsp_core_model_i.wr(16'h8123, 8'h3C);
      #1;
      chk("xram_wr", {xram.wr, xram.waddr, xram.wdata}, {1'b1, 16'h8123, 8'h3C});
      chk("fl_wr", fl_op.wr, 1'b0);
      apb(1'b1, OFS_PSC, 32'h1);
      fsp_core_model_i.rd(16'h0042);
      #1;
      chk("xram_rd", {xram.rd, xram.raddr, fl_rd.valid}, {1'b1, 16'h0042, 1'b0});
      fsp_core_model_i.wr(16'h0100, 8'h00);
      #1;
      chk("no_prog", {fl_op.wr, fl_op.erase, xram.wr}, 3'b000);
      rchk(OFS_PSC, 32'h1);
   endtask

   task automatic t_write;
      apb(1'b1, OFS_PBR, 32'h20);
      apb(1'b1, OFS_FSC, 32'h1);
      fsp_core_model_i.wr(16'h8123, 8'h5A);
      #1;
      chk("fl_wr", {fl_op.wr, fl_op.addr, fl_op.clr_mask, fl_op.len}, {1'b1, 18'h10123, 8'hA5, 11'h1});
      chk("busy", flash_busy_flag, 1'b1);
      busy_wait(W + 1);
      fsp_core_model_i.wr(16'h1234, 8'hF0);
      #1;
      chk("low_addr", {fl_op.wr, fl_op.addr}, {1'b1, 18'h01234});
      busy_wait(W + 1);
      apb(1'b1, OFS_PSC, 32'h5);
      fsp_core_model_i.wr(16'h0090, 8'h0F);
      #1;
      chk("scr_wr", {fl_op.wr, fl_op.addr, fl_op.clr_mask}, {1'b1, 18'h20090, 8'hF0});
      busy_wait(W + 1);
   endtask

   task automatic t_erase;
      logic [15:0] ea[3] = '{16'h0400, 16'h0085, 16'h0523};
      logic [17:0] xa[3] = '{18'h20000, 18'h20080, 18'h00400};
      logic [10:0] xl[3] = '{11'h100, 11'h080, 11'h400};
      for (int i = 0; i < 3; i++) begin
         // Enables raised in the documented order
         apb(1'b1, OFS_PSC, (i < 2) ? 32'h4 : 32'h0);
         apb(1'b1, OFS_PSC, (i < 2) ? 32'h6 : 32'h2);
         apb(1'b1, OFS_PSC, (i < 2) ? 32'h7 : 32'h3);
         fsp_core_model_i.wr(ea[i], 8'h00);
         #1;
         chk("erase", {fl_op.erase, fl_op.addr, fl_op.fill, fl_op.len}, {1'b1, xa[i], 8'hFF, xl[i]});
         fsp_core_model_i.wr(ea[i], 8'h00);
         #1;
         chk("busy_drop", {fl_op.erase, fl_op.wr}, 2'b00);
         busy_wait(E - 1);
      end
      apb(1'b1, OFS_PSC, 32'h0);
      apb(1'b1, OFS_FSC, 32'h0);
   endtask

   // Mid-run reset must drop every control bit back to its idle value
   task automatic t_reset;
      apb(1'b1, OFS_PSC, 32'h7);
      apb(1'b1, OFS_FSC, 32'h1);
      apb(1'b1, OFS_PBR, 32'h30);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rchk(OFS_PSC, 32'h0);
      rchk(OFS_FSC, 32'h0);
      rchk(OFS_PBR, 32'h10);
   endtask

   task automatic t_reads;
      logic [15:0] ca[4] = '{16'h0010, 16'h0010, 16'h9000, 16'h0010};
      logic        cf[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      logic [17:0] xa[4] = '{18'h20010, 18'h00010, 18'h19000, 18'h00010};
      apb(1'b1, OFS_PBR, 32'h30);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_PSC, (i < 3) ? 32'h4 : 32'h0);
         fsp_core_model_i.cr(ca[i], cf[i]);
         #1;
         chk("fl_rd", {fl_rd.valid, fl_rd.addr, xram.rd}, {1'b1, xa[i], 1'b0});
      end
   endtask

   initial begin
      mclk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = '0; pwdata = '0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      t_regs;
      t_xram;
      t_write;
      t_erase;
      t_reads;
      t_reset;
      wrap_up;
   end
endmodule
